// File: dv/main_clock_source_control_tb.sv
// self-checking bench of the main clock source controller
`timescale 1ns/10ps
module main_clock_source_control_tb;
  typedef struct packed
  {
    logic [5:0] idx;
    logic [7:0] data;
    logic key;
    logic [7:0] rb;
    logic [6:0] per;
  } row_s;

  localparam logic [6:0] CTR_FUSE = 7'h2A;
  localparam logic [3:0] SLP_FUSE = 4'h9;
  localparam logic [1:0] FQ_FUSE = 2'h1;
  localparam row_s ROWS [11] = '{
    '{clock_ctrl_pkg::LP_CTRL_IDX, 8'h02, 1'b1, 8'h02, 7'h00},
    '{clock_ctrl_pkg::PRESC_IDX, 8'h0B, 1'b1, 8'h0B, 7'h40},
    '{clock_ctrl_pkg::PRESC_IDX, 8'h00, 1'b0, 8'h0B, 7'h40},
    '{clock_ctrl_pkg::PRESC_IDX, 8'h01, 1'b1, 8'h01, 7'h02},
    '{clock_ctrl_pkg::PRESC_IDX, 8'h19, 1'b1, 8'h19, 7'h30},
    '{clock_ctrl_pkg::PRESC_IDX, 8'h1B, 1'b1, 8'h1B, 7'h30},
    '{clock_ctrl_pkg::PRESC_IDX, 8'h1A, 1'b1, 8'h1A, 7'h01},
    '{clock_ctrl_pkg::CENTER_IDX, 8'h15, 1'b1, 8'h15, 7'h00},
    '{clock_ctrl_pkg::CENTER_IDX, 8'h33, 1'b0, 8'h15, 7'h00},
    '{clock_ctrl_pkg::FAST_CTRL_IDX, 8'h02, 1'b1, 8'h02, 7'h00},
    '{6'h05, 8'hFF, 1'b1, 8'h00, 7'h00}
  };

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [1:0] sleep_mode = 2'h0;
  logic nvm_busy = 1'b0;
  logic [3:0] clk_req = 4'h0;
  logic main_req = 1'b0;
  logic [31:0] readdata;
  logic [3:0] osc_enable;
  logic [3:0] src_grant;
  logic lp_khz_tick;
  logic [1:0] fast_freq;
  logic [6:0] center_trim;
  logic [3:0] temp_slope_trim;
  logic waitrequest, fast_osc_tick, lp_osc_tick, xtal_pin_in;
  logic external_clock_input, main_clk_en, peripheral_clock;
  logic xtal_pins_own, ext_pin_own, xtal_pin_out_oe;
  logic switch_pending_flag, ext_clock_status, crystal_status;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  always #25 sys_clk = ~sys_clk;

  main_clock_source_control #(.XT_SU0(16'h0004), .KHZ_DIV(8'h02)) dut_u
  (
    .sys_clk, .reset, .ce(1'b1), .address, .read, .write, .writedata,
    .readdata, .waitrequest, .freq_choice_fuse(FQ_FUSE),
    .calibration_lock_fuse(1'b0), .center_trim_fuse(CTR_FUSE),
    .slope_trim_fuse(SLP_FUSE), .sleep_mode, .nvm_busy, .clk_req,
    .main_req, .fast_osc_tick, .lp_osc_tick, .xtal_pin_in,
    .external_clock_input, .osc_enable, .src_grant, .main_clk_en,
    .peripheral_clock, .clkout_tick(), .lp_khz_tick, .fast_freq,
    .center_trim, .temp_slope_trim, .xtal_pins_own, .ext_pin_own,
    .xtal_pin_out(), .xtal_pin_out_oe, .switch_pending_flag,
    .ext_clock_status, .crystal_status
  );

  osc_model osc_u
  (
    .sys_clk, .osc_enable, .fast_osc_tick, .lp_osc_tick, .xtal_pin_in,
    .external_clock_input
  );

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access, entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [5:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    do
      @(posedge sys_clk);
    while (waitrequest !== 1'b0);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pwr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, clock_ctrl_pkg::PROT_IDX, clock_ctrl_pkg::PROT_KEY, q);
    bus(1'b1, idx, d, q);
  endtask

  task automatic period(output logic [6:0] p);
    int n;
    n = 0;
    p = 7'h00;
    @(negedge sys_clk);
    while (peripheral_clock !== 1'b1 && ++n < 300)
      @(negedge sys_clk);
    do
    begin
      @(negedge sys_clk);
      p++;
    end
    while (peripheral_clock !== 1'b1 && p < 7'h7F);
    @(posedge sys_clk);
  endtask

  task automatic ticks(output logic [7:0] c, output logic [7:0] k);
    c = 8'h00;
    k = 8'h00;
    repeat (40)
    begin
      @(negedge sys_clk);
      c = c + {7'h00, main_clk_en};
      k = k + {7'h00, lp_khz_tick};
    end
    @(posedge sys_clk);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial
  begin
    logic [7:0] q;
    logic [7:0] c;
    logic [7:0] k;
    logic [6:0] p;
    int n;
    do_reset();
    foreach (ROWS[i])
    begin
      if (ROWS[i].key)
        pwr(ROWS[i].idx, ROWS[i].data);
      else
        bus(1'b1, ROWS[i].idx, ROWS[i].data, q);
      bus(1'b0, ROWS[i].idx, 8'h00, q);
      chk("register", {24'h0, ROWS[i].rb}, {24'h0, q});
      if (ROWS[i].per != 7'h00)
      begin
        period(p);
        chk("divide", {25'h0, ROWS[i].per}, {25'h0, p});
      end
    end
    // sleep modes with both internal sources held in standby
    sleep_mode <= 2'h2;
    ticks(c, k);
    chk("standby ticks", 32'd40, {24'h0, c});
    chk("khz ticks", 32'd5, {24'h0, k});
    chk("standby lp on", 32'h3, {30'h0, osc_enable[1], src_grant[1]});
    sleep_mode <= 2'h3;
    nvm_busy <= 1'b1;
    ticks(c, k);
    chk("nvm busy ticks", 32'd40, {24'h0, c});
    chk("pdown lp off", 32'h0, {31'h0, osc_enable[1]});
    nvm_busy <= 1'b0;
    @(posedge sys_clk);
    ticks(c, k);
    chk("pdown ticks", 32'd0, {24'h0, c});
    sleep_mode <= 2'h0;
    // crystal across both pins, requested then released
    pwr(clock_ctrl_pkg::XTAL_CTRL_IDX, 8'h01);
    chk("xtal pins", 32'h3, {30'h0, xtal_pins_own, xtal_pin_out_oe});
    clk_req <= 4'h4;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("xtal early", 32'h0, {31'h0, crystal_status});
    n = 0;
    while (crystal_status !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("xtal ready", 32'h1, {31'h0, n >= 6 && n < 200});
    @(posedge sys_clk);
    clk_req <= 4'h0;
    repeat (4) @(posedge sys_clk);
    chk("xtal off", 32'h0, {30'h0, osc_enable[2], crystal_status});
    pwr(clock_ctrl_pkg::XTAL_CTRL_IDX, 8'h05);
    chk("pin clock", 32'h2, {30'h0, xtal_pins_own, xtal_pin_out_oe});
    // switch to the external clock, a second change refused meanwhile
    pwr(clock_ctrl_pkg::MAIN_SRC_IDX, 8'h03);
    @(negedge sys_clk);
    chk("pending", 32'h3, {30'h0, switch_pending_flag, ext_pin_own});
    @(posedge sys_clk);
    pwr(clock_ctrl_pkg::MAIN_SRC_IDX, 8'h01);
    n = 0;
    while (switch_pending_flag !== 1'b0 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("ext started", 32'h1, {31'h0, ext_clock_status});
    @(posedge sys_clk);
    bus(1'b0, clock_ctrl_pkg::MAIN_SRC_IDX, 8'h00, q);
    chk("source", 32'h3, {30'h0, q[1:0]});
    // second reset in mid-run restores the defaults
    do_reset();
    bus(1'b0, clock_ctrl_pkg::MAIN_SRC_IDX, 8'h00, q);
    chk("source reset", 32'h0, {24'h0, q});
    bus(1'b0, clock_ctrl_pkg::PRESC_IDX, 8'h00, q);
    chk("presc reset", 32'h11, {24'h0, q});
    period(p);
    chk("divide reset", 32'h6, {25'h0, p});
    chk("trims", {17'h0, FQ_FUSE, CTR_FUSE, 2'h0, SLP_FUSE},
      {17'h0, fast_freq, center_trim, 2'h0, temp_slope_trim});
    pwr(clock_ctrl_pkg::LOCK_IDX, 8'h01);
    pwr(clock_ctrl_pkg::CENTER_IDX, 8'h40);
    bus(1'b0, clock_ctrl_pkg::CENTER_IDX, 8'h00, q);
    chk("locked trim", {25'h0, CTR_FUSE}, {24'h0, q});
    wrap_up();
  end
endmodule // main_clock_source_control_tb

// File: dv/osc_model.sv
// oscillator and pin activity model facing the clock controller
`timescale 1ns/10ps
module osc_model
(
  // clock
  input wire logic sys_clk,
  // switched-on sources
  input wire logic [3:0] osc_enable,
  // source activity
  output logic fast_osc_tick,
  output logic lp_osc_tick,
  output logic xtal_pin_in,
  output logic external_clock_input
);
  logic [3:0] cnt_ff;

  initial
  begin
    cnt_ff = 4'h0;
    fast_osc_tick = 1'b0;
    lp_osc_tick = 1'b0;
    xtal_pin_in = 1'b0;
    external_clock_input = 1'b0;
  end

  // a stopped source holds low, so it gives no stray edges
  always @(posedge sys_clk)
  begin
    cnt_ff <= cnt_ff + 4'h1;
    fast_osc_tick <= osc_enable[0];
    lp_osc_tick <= osc_enable[1] & (cnt_ff[1:0] == 2'h0);
    xtal_pin_in <= osc_enable[2] & cnt_ff[0];
    external_clock_input <= osc_enable[3] & cnt_ff[2];
  end
endmodule // osc_model

// File: verilog/clk_prescaler.sv
// main clock prescaler producing peripheral clock ticks
`timescale 1ns/10ps
module clk_prescaler
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // main clock ticks and setting
  input wire logic tick_in,
  input wire logic prescale_enable,
  input wire logic [3:0] prescale_divisor,
  // peripheral clock tick
  output logic tick_out
);
  logic [6:0] div_ff;
  logic [6:0] cnt_ff;
  logic [6:0] want;

  // reserved codes leave the running divisor in place
  assign want = prescale_enable ? clock_ctrl_pkg::div_of(prescale_divisor) : 7'h01;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      div_ff <= clock_ctrl_pkg::div_of(clock_ctrl_pkg::PRESC_RST[4:1]);
      cnt_ff <= 7'h00;
      tick_out <= 1'b0;
    end
    else if (ce)
    begin
      tick_out <= 1'b0;
      if (tick_in)
      begin
        if (cnt_ff + 7'h01 >= div_ff)
        begin
          cnt_ff <= 7'h00;
          tick_out <= 1'b1;
          // new divisor only at a period boundary, no runt pulses
          if (want != 7'h00)
            div_ff <= want;
        end
        else
          cnt_ff <= cnt_ff + 7'h01;
      end
    end
  end

  bypass_pass_a: assert property (@(posedge sys_clk) disable iff (reset)
    ce && tick_in && div_ff == 7'h01 |=> tick_out)
    else $error("undivided tick lost");
  no_runt_a: assert property (@(posedge sys_clk) disable iff (reset)
    tick_out |-> cnt_ff == 7'h00) else $error("tick off boundary");
endmodule // clk_prescaler

// File: verilog/clock_ctrl_pkg.sv
// constants, types and decoders of the main clock source controller
package clock_ctrl_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] MAIN_SRC_IDX = 6'h00;
  localparam logic [5:0] PRESC_IDX = 6'h01;
  localparam logic [5:0] LOCK_IDX = 6'h02;
  localparam logic [5:0] STATE_IDX = 6'h03;
  localparam logic [5:0] FAST_CTRL_IDX = 6'h10;
  localparam logic [5:0] CENTER_IDX = 6'h11;
  localparam logic [5:0] SLOPE_IDX = 6'h12;
  localparam logic [5:0] LP_CTRL_IDX = 6'h18;
  localparam logic [5:0] XTAL_CTRL_IDX = 6'h1C;
  localparam logic [5:0] PROT_IDX = 6'h20;
  // field positions
  localparam int CLKOUT_BIT = 7;
  localparam int RSB_BIT = 1;
  localparam int XT_EN_BIT = 0;
  localparam int XT_SEL_BIT = 2;
  localparam int CRYSTAL_STARTUP_TIME_LSB = 4;
  // reset values
  localparam logic [4:0] PRESC_RST = 5'h11;
  // protection key (arbitrary value) and open window in clocks
  localparam logic [7:0] PROT_KEY = 8'hA5;
  localparam logic [2:0] PROT_WINDOW = 3'h4;
  // start-up figures in oscillator cycles
  localparam logic [15:0] EXT_START = 16'h0002;
  localparam logic [15:0] LP_EXTRA = 16'h0004;

  typedef enum logic [1:0] {
    SRC_FAST = 2'b00,
    SRC_LP = 2'b01,
    SRC_XTAL = 2'b10,
    SRC_EXT = 2'b11
  } src_e;

  typedef enum logic [1:0] {
    SLP_ACTIVE = 2'b00,
    SLP_IDLE = 2'b01,
    SLP_STANDBY = 2'b10,
    SLP_PDOWN = 2'b11
  } sleep_e;

  typedef enum logic {
    SW_IDLE = 1'b0,
    SW_WAIT = 1'b1
  } sw_state_e;

  // divisor of a prescale code, zero for reserved codes
  function automatic logic [6:0] div_of(input logic [3:0] code);
    case (code)
      4'h0: return 7'h02;
      4'h1: return 7'h04;
      4'h2: return 7'h08;
      4'h3: return 7'h10;
      4'h4: return 7'h20;
      4'h5: return 7'h40;
      4'h8: return 7'h06;
      4'h9: return 7'h0A;
      4'hA: return 7'h0C;
      4'hB: return 7'h18;
      4'hC: return 7'h30;
      default: return 7'h00;
    endcase
  endfunction
endpackage

// File: verilog/main_clock_source_control.sv
// main clock source control with register slave
`timescale 1ns/10ps
// Summary of operation
// - unrequested, non-standby sources are switched off
// - run-in-standby keeps source on except power-down
// - standby-held source is granted without start-up
// - main clock runs awake, in standby on demand
// - power-down stops main clock after nvm done
// - pending switch waits edges, refuses changes
// - pending flag high during a source switch
// - each source status shows running and stable
// - prescaler divides main clock by 1 to 64
// - source and prescaler writes need the unlock
// - reset selects fast oscillator, divide by six
// - trims load from fuses during reset
// - internal sources auto start, crystal needs enable
// - calibration lock by fuse, or main lock while fast oscillator selected
// - calibration writes need the unlock
// - low-power source gives a 1 kHz tick
// - low-power ready after start-up plus four
// - source-select picks crystal or pin clock
// - enabled crystal takes over both pins
// - crystal waits its chosen start-up time
// - pin clock on crystal input starts in two
// - external pin claimed on request, two cycles
// - source codes fast, low-power, crystal, external
// - divisor code table, others reserved
// - prescale disabled passes main clock undivided
module main_clock_source_control
#(
  parameter logic [15:0] FAST_SU = 16'h0008,
  parameter logic [15:0] LP_SU = 16'h0010,
  parameter logic [15:0] XT_SU0 = 16'h0010,
  parameter logic [15:0] XT_SU1 = 16'h0020,
  parameter logic [15:0] XT_SU2 = 16'h0040,
  parameter logic [15:0] XT_SU3 = 16'h0080,
  parameter logic [7:0] KHZ_DIV = 8'h20
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // fuses
  input wire logic [1:0] freq_choice_fuse,
  input wire logic calibration_lock_fuse,
  input wire logic [6:0] center_trim_fuse,
  input wire logic [3:0] slope_trim_fuse,
  // sleep controller and requests
  input wire logic [1:0] sleep_mode,
  input wire logic nvm_busy,
  input wire logic [3:0] clk_req,
  input wire logic main_req,
  // source activity
  input wire logic fast_osc_tick,
  input wire logic lp_osc_tick,
  input wire logic xtal_pin_in,
  input wire logic external_clock_input,
  // source control and clocks
  output logic [3:0] osc_enable,
  output logic [3:0] src_grant,
  output logic main_clk_en,
  output logic peripheral_clock,
  output logic clkout_tick,
  output logic lp_khz_tick,
  // trims and pins
  output logic [1:0] fast_freq,
  output logic [6:0] center_trim,
  output logic [3:0] temp_slope_trim,
  output logic xtal_pins_own,
  output logic ext_pin_own,
  output logic xtal_pin_out,
  output logic xtal_pin_out_oe,
  // status
  output logic switch_pending_flag,
  output logic ext_clock_status,
  output logic crystal_status
);
  clock_ctrl_pkg::src_e sel_ff;
  clock_ctrl_pkg::src_e target_ff;
  clock_ctrl_pkg::src_e new_src;
  clock_ctrl_pkg::sw_state_e sw_ff;
  logic done_ff, clkout_ff, lock_ff, xt_en_ff, xt_sel_ff;
  logic rsb_fast_ff, rsb_lp_ff, rsb_xt_ff, xt_q_ff, ext_q_ff;
  logic [1:0] crystal_startup_time_ff;
  logic [2:0] prot_cnt_ff;
  logic [4:0] presc_ff;
  logic [7:0] khz_cnt_ff;
  logic [5:0] idx;
  logic wr_acc, unlocked, src_wr, cal_block, cal_ok;
  logic awake, standby, pdown, main_run;
  logic [3:0] rsb, gate, need, osc_on, ready, tick;
  logic [15:0] lim [4];

  // register write hit on an index
  function automatic logic hit(input logic [5:0] i);
    return wr_acc && idx == i;
  endfunction

  // bus slave: one wait state for every access
  assign idx = address[7:2];
  assign waitrequest = (read | write) & ~(done_ff & ce);
  assign wr_acc = write & done_ff & ce;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      done_ff <= 1'b0;
    else if (ce)
      done_ff <= (read | write) & ~done_ff;
  end

  // key write opens a short window for one protected write
  assign unlocked = prot_cnt_ff != 3'h0;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      prot_cnt_ff <= 3'h0;
    else if (ce)
    begin
      if (hit(clock_ctrl_pkg::PROT_IDX))
        prot_cnt_ff <= writedata[7:0] == clock_ctrl_pkg::PROT_KEY ?
          clock_ctrl_pkg::PROT_WINDOW : 3'h0;
      else if (wr_acc)
        prot_cnt_ff <= 3'h0;
      else if (unlocked)
        prot_cnt_ff <= prot_cnt_ff - 3'h1;
    end
  end

  // sleep state and demand on each source
  assign awake = sleep_mode == clock_ctrl_pkg::SLP_ACTIVE ||
    sleep_mode == clock_ctrl_pkg::SLP_IDLE;
  assign standby = sleep_mode == clock_ctrl_pkg::SLP_STANDBY;
  assign pdown = sleep_mode == clock_ctrl_pkg::SLP_PDOWN;
  assign main_run = awake ||
    (standby && (main_req || rsb[sel_ff])) ||
    (pdown && nvm_busy);
  assign rsb = {1'b0, rsb_xt_ff, rsb_lp_ff, rsb_fast_ff};
  assign gate = {1'b1, xt_en_ff, 2'b11};
  assign tick = {external_clock_input & ~ext_q_ff,
    xtal_pin_in & ~xt_q_ff, lp_osc_tick, fast_osc_tick};

  always_comb
  begin
    lim[0] = FAST_SU;
    lim[1] = LP_SU + clock_ctrl_pkg::LP_EXTRA;
    lim[3] = clock_ctrl_pkg::EXT_START;
    if (xt_sel_ff)
      lim[2] = clock_ctrl_pkg::EXT_START;
    else if (crystal_startup_time_ff == 2'b00)
      lim[2] = XT_SU0;
    else if (crystal_startup_time_ff == 2'b01)
      lim[2] = XT_SU1;
    else if (crystal_startup_time_ff == 2'b10)
      lim[2] = XT_SU2;
    else
      lim[2] = XT_SU3;
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_src
    assign need[i] = (main_run && sel_ff == 2'(i)) ||
      (sw_ff == clock_ctrl_pkg::SW_WAIT && target_ff == 2'(i));
    // off unless requested or held by run-in-standby
    assign osc_on[i] = (clk_req[i] || need[i] || (rsb[i] && !pdown))
      && gate[i];
    osc_start_timer #(.TW(16)) u_timer
    (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .run(osc_on[i]),
      .tick(tick[i]),
      .limit(lim[i]),
      .ready(ready[i])
    );
  end

  // a held source is already counted out, so grant is immediate
  assign osc_enable = osc_on;
  assign src_grant = osc_on & ready;
  assign ext_clock_status = ready[clock_ctrl_pkg::SRC_EXT];
  assign crystal_status = ready[clock_ctrl_pkg::SRC_XTAL];
  assign switch_pending_flag = sw_ff == clock_ctrl_pkg::SW_WAIT;

  // main clock ticks only from a ready selected source
  assign main_clk_en = main_run && ready[sel_ff] && tick[sel_ff];

  clk_prescaler u_presc
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .tick_in(main_clk_en),
    .prescale_enable(presc_ff[0]),
    .prescale_divisor(presc_ff[4:1]),
    .tick_out(peripheral_clock)
  );
  assign clkout_tick = peripheral_clock & clkout_ff;

  // crystal pins and external pin ownership
  assign xtal_pins_own = xt_en_ff;
  assign xtal_pin_out = ~xtal_pin_in;
  assign xtal_pin_out_oe = xt_en_ff & ~xt_sel_ff;
  assign ext_pin_own = osc_on[clock_ctrl_pkg::SRC_EXT];

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      xt_q_ff <= 1'b0;
      ext_q_ff <= 1'b0;
    end
    else if (ce)
    begin
      xt_q_ff <= xtal_pin_in;
      ext_q_ff <= external_clock_input;
    end
  end

  // 1 khz tick from the low-power source
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      khz_cnt_ff <= 8'h00;
      lp_khz_tick <= 1'b0;
    end
    else if (ce)
    begin
      lp_khz_tick <= 1'b0;
      if (tick[1] && src_grant[1])
      begin
        if (khz_cnt_ff + 8'h01 >= KHZ_DIV)
        begin
          khz_cnt_ff <= 8'h00;
          lp_khz_tick <= 1'b1;
        end
        else
          khz_cnt_ff <= khz_cnt_ff + 8'h01;
      end
    end
  end

  // source select with switch held until the new source is stable
  assign new_src = clock_ctrl_pkg::src_e'(writedata[1:0]);
  assign src_wr = hit(clock_ctrl_pkg::MAIN_SRC_IDX) && unlocked
    && !lock_ff;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sel_ff <= clock_ctrl_pkg::SRC_FAST;
      target_ff <= clock_ctrl_pkg::SRC_FAST;
      sw_ff <= clock_ctrl_pkg::SW_IDLE;
      clkout_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (src_wr)
        clkout_ff <= writedata[clock_ctrl_pkg::CLKOUT_BIT];
      case (sw_ff)
        clock_ctrl_pkg::SW_IDLE:
          if (src_wr && new_src != sel_ff)
          begin
            target_ff <= new_src;
            sw_ff <= clock_ctrl_pkg::SW_WAIT;
          end
        clock_ctrl_pkg::SW_WAIT:
          // further selections refused until the edges arrive
          if (ready[target_ff])
          begin
            sel_ff <= target_ff;
            sw_ff <= clock_ctrl_pkg::SW_IDLE;
          end
        default:
          sw_ff <= clock_ctrl_pkg::SW_IDLE;
      endcase
    end
  end

  // prescaler, lock and source control registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      presc_ff <= clock_ctrl_pkg::PRESC_RST;
      lock_ff <= calibration_lock_fuse;
      rsb_fast_ff <= 1'b0;
      rsb_lp_ff <= 1'b0;
      rsb_xt_ff <= 1'b0;
      xt_en_ff <= 1'b0;
      xt_sel_ff <= 1'b0;
      crystal_startup_time_ff <= 2'b00;
    end
    else if (ce && unlocked)
    begin
      if (hit(clock_ctrl_pkg::PRESC_IDX) && !lock_ff)
        presc_ff <= writedata[4:0];
      else if (hit(clock_ctrl_pkg::LOCK_IDX) && !lock_ff)
        lock_ff <= writedata[0];
      else if (hit(clock_ctrl_pkg::FAST_CTRL_IDX))
        rsb_fast_ff <= writedata[clock_ctrl_pkg::RSB_BIT];
      else if (hit(clock_ctrl_pkg::LP_CTRL_IDX))
        rsb_lp_ff <= writedata[clock_ctrl_pkg::RSB_BIT];
      else if (hit(clock_ctrl_pkg::XTAL_CTRL_IDX))
      begin
        xt_en_ff <= writedata[clock_ctrl_pkg::XT_EN_BIT];
        rsb_xt_ff <= writedata[clock_ctrl_pkg::RSB_BIT];
        xt_sel_ff <= writedata[clock_ctrl_pkg::XT_SEL_BIT];
        crystal_startup_time_ff <= writedata[clock_ctrl_pkg::CRYSTAL_STARTUP_TIME_LSB +: 2];
      end
    end
  end

  // calibration loaded from fuses, then protected and lockable
  assign cal_block = calibration_lock_fuse ||
    (sel_ff == clock_ctrl_pkg::SRC_FAST && lock_ff);
  assign cal_ok = unlocked && !cal_block;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      center_trim <= center_trim_fuse;
      temp_slope_trim <= slope_trim_fuse;
      fast_freq <= freq_choice_fuse;
    end
    else if (ce && cal_ok)
    begin
      if (hit(clock_ctrl_pkg::CENTER_IDX))
        center_trim <= writedata[6:0];
      else if (hit(clock_ctrl_pkg::SLOPE_IDX))
        temp_slope_trim <= writedata[3:0];
    end
  end

  // read data settles in the wait state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      readdata <= 32'h0;
    else if (ce && read && !done_ff)
    begin
      if (idx == clock_ctrl_pkg::MAIN_SRC_IDX)
        readdata <= {24'h0, clkout_ff, 5'h0, sel_ff};
      else if (idx == clock_ctrl_pkg::PRESC_IDX)
        readdata <= {27'h0, presc_ff};
      else if (idx == clock_ctrl_pkg::LOCK_IDX)
        readdata <= {31'h0, lock_ff};
      else if (idx == clock_ctrl_pkg::STATE_IDX)
        readdata <= {24'h0, ready[3], ready[2], ready[1], ready[0],
          3'h0, switch_pending_flag};
      else if (idx == clock_ctrl_pkg::FAST_CTRL_IDX)
        readdata <= {30'h0, rsb_fast_ff, 1'b0};
      else if (idx == clock_ctrl_pkg::CENTER_IDX)
        readdata <= {25'h0, center_trim};
      else if (idx == clock_ctrl_pkg::SLOPE_IDX)
        readdata <= {24'h0, calibration_lock_fuse, 3'h0, temp_slope_trim};
      else if (idx == clock_ctrl_pkg::LP_CTRL_IDX)
        readdata <= {30'h0, rsb_lp_ff, 1'b0};
      else if (idx == clock_ctrl_pkg::XTAL_CTRL_IDX)
        readdata <= {26'h0, crystal_startup_time_ff, 1'b0, xt_sel_ff, rsb_xt_ff, xt_en_ff};
      else
        readdata <= 32'h0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence src_take;
    ce && src_wr && sw_ff == clock_ctrl_pkg::SW_IDLE && new_src != sel_ff;
  endsequence
  sequence src_pending;
    switch_pending_flag && target_ff == $past(new_src);
  endsequence

  off_unreq_a: assert property (!clk_req[0] && !need[0] &&
    !(rsb[0] && !pdown) |-> !osc_enable[0]) else $error("idle source on");
  rsb_run_a: assert property (rsb_fast_ff && !pdown |->
    osc_enable[0]) else $error("standby-held source off");
  rsb_grant_a: assert property ((rsb_lp_ff && !pdown && ready[1]
    && ce) ##1 (rsb_lp_ff && !pdown) |-> src_grant[1])
    else $error("held source not granted");
  main_awake_a: assert property (awake && ready[sel_ff] &&
    tick[sel_ff] |-> main_clk_en) else $error("main clock stalled awake");
  pdown_stop_a: assert property (pdown && !nvm_busy |->
    !main_clk_en) else $error("main clock ran in power-down");
  switch_hold_a: assert property (switch_pending_flag &&
    !ready[target_ff] |=> $stable(target_ff) && $stable(sel_ff))
    else $error("pending switch changed");
  switch_start_a: assert property (src_take |=> src_pending)
    else $error("switch not flagged pending");
  prot_write_a: assert property (hit(clock_ctrl_pkg::PRESC_IDX) &&
    !unlocked |=> $stable(presc_ff)) else $error("unprotected write");
  reset_dflt_a: assert property ($fell(reset) |->
    sel_ff == clock_ctrl_pkg::SRC_FAST &&
    presc_ff == clock_ctrl_pkg::PRESC_RST) else $error("bad reset clock");
  cal_lock_a: assert property (hit(clock_ctrl_pkg::CENTER_IDX) &&
    cal_block |=> $stable(center_trim)) else $error("locked trim changed");
  xtal_gate_a: assert property (!xt_en_ff |->
    !osc_enable[2] && !xtal_pin_out_oe) else $error("crystal runs disabled");
endmodule // main_clock_source_control

// File: verilog/osc_start_timer.sv
// start-up counter of one clock source
`timescale 1ns/10ps
module osc_start_timer
#(
  parameter int TW = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  // source
  input wire logic run,
  input wire logic tick,
  input wire logic [TW-1:0] limit,
  // result
  output logic ready
);
  logic [TW-1:0] cnt_ff;
  logic [TW-1:0] nxt_cnt;

  assign nxt_cnt = cnt_ff + TW'(1);

  // count source edges while running, restart when stopped
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt_ff <= '0;
      ready <= 1'b0;
    end
    else if (ce && !run)
    begin
      cnt_ff <= '0;
      ready <= 1'b0;
    end
    else if (ce && tick && !ready)
    begin
      cnt_ff <= nxt_cnt;
      ready <= nxt_cnt >= limit;
    end
  end

  stop_clears_a: assert property (@(posedge sys_clk) disable iff (reset)
    ce && !run |=> !ready) else $error("ready kept after stop");
  count_reach_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(ready) |-> cnt_ff >= limit && run)
    else $error("ready before start-up count");
endmodule // osc_start_timer
